//--- mmir_pkg.sv
// constants and types for the modem mode and interrupt register bank
// What this block does
// - blind_dial_now set: dial at once after tone-dial command, no dial-tone wait
// - v23_receive_side: send 75, receive 600 or 1200 chosen by baud bit
// - v23_transmit_side: send 600 or 1200 by baud bit, receive 75
// - both V.23 bits clear: baud bit picks 1200 (0) or 2400 (1)
// - both V.23 bits set: baud bit picks 600 (0) or 1200 (1)
// - carrier_loss_mask bit 7: carrier flag falling raises interrupt
// - wake_ring_mask bit 6: wake flag rising raises interrupt
// - extension_phone_mask bit 5, no_line_mask bit 4 gate their flag rises
// - ring_event_mask bit 3, caller_info_mask bit 2 gate their flag rises
// - reversal_mask bit 0: reversal flag rising raises interrupt
// - carrier flag sticky, high when carrier pin low, cleared by status read
// - wake-on-ring flag latches on event, clears on status read
// - extension phone flag latches on extension event once any off-hook has been seen since reset, clears on read
// - no-line flag latches on missing line, clears on read
// - ring flag latches on ring while on-hook, clears on read
// - caller-ID flag latches on preamble, clears on read
// - reversal flag latches on V.23 reversal, clears on read
// - carrier_pin_enable makes pin two an active-low carrier output; host sets function 01
// - caller monitor: 00 off, 01 seizure plus marks, 10 reserved, 11 marks only
// - extra_bit_meaning, only with escape enabled: 0 alert, 1 frame end
// - timeout_blind_dial: dial blind when dial-tone wait expires
// - band_swap_loopback swaps transmit and receive bands for test
// - irq_polarity: 0 active interrupt drives low, 1 drives high
package mmir_pkg;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_FEATURE = 4'h3;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [7:0] MODE_RESET = 8'h06;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h77;
  localparam logic [7:0] MASK_WMASK = 8'hfd;
  localparam logic [7:0] STATUS_MASK = 8'hfd;
  localparam logic [7:0] FEATURE_WMASK = 8'hee;
  localparam logic [7:0] CONTROL_WMASK = 8'h03;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int BIT_BLIND = 6;
  localparam int BIT_V23_RECEIVE_SIDE = 5;
  localparam int BIT_V23_TRANSMIT_SIDE = 4;
  localparam int BIT_BAUD = 2;
  localparam int BIT_CCITT = 1;
  localparam int BIT_FSK = 0;
  localparam int BIT_CARRIER = 7;
  localparam int BIT_WAKE = 6;
  localparam int BIT_EXT = 5;
  localparam int BIT_NOLINE = 4;
  localparam int BIT_RING = 3;
  localparam int BIT_CALLER = 2;
  localparam int BIT_REV = 0;
  localparam int BIT_CPIN = 7;
  localparam int BIT_CMON = 5;
  localparam int BIT_XBIT = 3;
  localparam int BIT_TBLIND = 2;
  localparam int BIT_LOOP = 1;
  localparam int BIT_IRQPOL = 0;
  localparam int BIT_ESC = 1;
  localparam logic [1:0] CPIN_FUNC_CARRIER = 2'h1;
  typedef enum logic [3:0] {
    MMIR_RATE_1200 = 4'h1,
    MMIR_RATE_2400 = 4'h2,
    MMIR_RATE_600 = 4'h4,
    MMIR_RATE_75 = 4'h8
  } mmir_rate_t;
  typedef enum logic [1:0] {
    MMIR_CMON_OFF = 2'h0,
    MMIR_CMON_SEIZE = 2'h1,
    MMIR_CMON_RSVD = 2'h2,
    MMIR_CMON_MARKS = 2'h3
  } mmir_cmon_t;
  typedef enum logic [2:0] {
    MMIR_BUS_IDLE = 3'b001,
    MMIR_BUS_ANSWER = 3'b010,
    MMIR_BUS_DONE = 3'b100
  } mmir_bus_t;
endpackage

//--- mmir_regs.sv
// modem mode and interrupt register bank behind an Avalon-MM slave
`timescale 1ns/10ps
module mmir_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  input wire logic carrier_pin_n,
  input wire logic wake_event,
  input wire logic extension_event,
  input wire logic off_hook_event,
  input wire logic line_absent_event,
  input wire logic ring_event,
  input wire logic on_hook,
  input wire logic caller_preamble,
  input wire logic reversal_event,
  input wire logic tone_dial_cmd,
  input wire logic dial_wait_expired,
  input wire logic [1:0] general_pin_two_func,
  output logic irq,
  output logic general_pin_two_out,
  output logic general_pin_two_oe,
  output logic start_dial,
  output mmir_pkg::mmir_rate_t tx_rate,
  output mmir_pkg::mmir_rate_t rx_rate,
  output logic ccitt_mode,
  output logic fsk_300,
  output mmir_pkg::mmir_cmon_t caller_monitor_sel,
  output logic caller_need_seizure,
  output logic extra_bit_alert,
  output logic extra_bit_frame_end,
  output logic band_swap_loopback
);
  import mmir_pkg::*;

  logic [7:0] modem_mode_select;
  logic [7:0] interrupt_mask;
  logic [7:0] interrupt_status;
  logic [7:0] modem_feature_control;
  logic [7:0] link_control;
  mmir_bus_t bus_state;
  logic [1:0] carrier_sync;
  logic [1:0] wake_sync;
  logic [1:0] ext_sync;
  logic [1:0] offhook_sync;
  logic [1:0] noline_sync;
  logic [1:0] ring_sync;
  logic [1:0] onhook_sync;
  logic [1:0] caller_sync;
  logic [1:0] rev_sync;
  logic [1:0] tone_sync;
  logic [1:0] wait_sync;
  logic [1:0] func_sync0;
  logic [1:0] func_sync1;
  logic carrier_now;
  logic tone_prev;
  logic wait_prev;
  logic [7:0] event_set;
  logic [7:0] prev_status;
  logic irq_pending;
  logic status_read;
  logic wr_take;
  logic [7:0] wdata;
  logic [7:0] next_rd;
  logic ext_since_offhook;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
                                       input logic [7:0] wm);
    merge = (old & ~wm) | (nv & wm);
  endfunction

  // two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      carrier_sync <= 2'h3;
      wake_sync <= 2'h0;
      ext_sync <= 2'h0;
      offhook_sync <= 2'h0;
      noline_sync <= 2'h0;
      ring_sync <= 2'h0;
      onhook_sync <= 2'h0;
      caller_sync <= 2'h0;
      rev_sync <= 2'h0;
      tone_sync <= 2'h0;
      wait_sync <= 2'h0;
      func_sync0 <= 2'h0;
      func_sync1 <= 2'h0;
    end else begin
      carrier_sync <= {carrier_sync[0], carrier_pin_n};
      wake_sync <= {wake_sync[0], wake_event};
      ext_sync <= {ext_sync[0], extension_event};
      offhook_sync <= {offhook_sync[0], off_hook_event};
      noline_sync <= {noline_sync[0], line_absent_event};
      ring_sync <= {ring_sync[0], ring_event};
      onhook_sync <= {onhook_sync[0], on_hook};
      caller_sync <= {caller_sync[0], caller_preamble};
      rev_sync <= {rev_sync[0], reversal_event};
      tone_sync <= {tone_sync[0], tone_dial_cmd};
      wait_sync <= {wait_sync[0], dial_wait_expired};
      func_sync0 <= general_pin_two_func;
      func_sync1 <= func_sync0;
    end
  end

  assign carrier_now = ~carrier_sync[1];

  // extension flag qualifies once any off-hook has been seen since reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_since_offhook <= 1'b0;
    end else if (offhook_sync[1]) begin
      ext_since_offhook <= 1'b1;
    end
  end

  always_comb begin
    event_set = 8'h00;
    event_set[BIT_CARRIER] = carrier_now;
    event_set[BIT_WAKE] = wake_sync[1];
    event_set[BIT_EXT] = ext_sync[1] & ext_since_offhook;
    event_set[BIT_NOLINE] = noline_sync[1];
    event_set[BIT_RING] = ring_sync[1] & onhook_sync[1];
    event_set[BIT_CALLER] = caller_sync[1];
    event_set[BIT_REV] = rev_sync[1];
  end

  // bus: request seen in idle, answered two cycles later with waitrequest low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_state <= MMIR_BUS_IDLE;
    end else begin
      unique case (bus_state)
        MMIR_BUS_IDLE: begin
          if (read || write) begin
            bus_state <= MMIR_BUS_ANSWER;
          end
        end
        MMIR_BUS_ANSWER: begin
          bus_state <= MMIR_BUS_DONE;
        end
        MMIR_BUS_DONE: begin
          bus_state <= MMIR_BUS_IDLE;
        end
      endcase
    end
  end

  assign wr_take = (bus_state == MMIR_BUS_ANSWER) && write && byteenable[0];
  assign status_read = (bus_state == MMIR_BUS_ANSWER) && read && (address == ADDR_STATUS);
  assign wdata = writedata[7:0];

  always_comb begin
    unique case (address)
      ADDR_MODE: next_rd = modem_mode_select;
      ADDR_MASK: next_rd = interrupt_mask;
      ADDR_STATUS: next_rd = interrupt_status;
      ADDR_FEATURE: next_rd = modem_feature_control;
      ADDR_CONTROL: next_rd = link_control;
      default: next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
      response <= 2'h0;
    end else begin
      waitrequest <= !(bus_state == MMIR_BUS_ANSWER);
      if (bus_state == MMIR_BUS_ANSWER) begin
        readdata <= read ? {24'h0, next_rd} : 32'h0;
        response <= (address > ADDR_CONTROL) ? 2'h2 : 2'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      modem_mode_select <= MODE_RESET;
      interrupt_mask <= MASK_RESET;
      modem_feature_control <= FEATURE_RESET;
      link_control <= CONTROL_RESET;
    end else if (wr_take) begin
      unique case (address)
        ADDR_MODE: modem_mode_select <= merge(modem_mode_select, wdata, MODE_WMASK);
        ADDR_MASK: interrupt_mask <= merge(interrupt_mask, wdata, MASK_WMASK);
        ADDR_FEATURE: modem_feature_control <= merge(modem_feature_control, wdata,
                                                     FEATURE_WMASK);
        ADDR_CONTROL: link_control <= merge(link_control, wdata, CONTROL_WMASK);
        default: ;
      endcase
    end
  end

  // sticky flags: a set in the clearing read's cycle wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_status <= 8'h00;
    end else begin
      interrupt_status <= ((status_read ? 8'h00 : interrupt_status) | event_set)
                          & STATUS_MASK;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_status <= 8'h00;
    end else begin
      prev_status <= interrupt_status;
    end
  end

  // pending holds until the flags are cleared by a status read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_pending <= 1'b0;
    end else begin
      // carrier loss is the sticky flag falling, so it shows once a read clears it
      if (interrupt_mask[BIT_CARRIER] && prev_status[BIT_CARRIER]
          && !interrupt_status[BIT_CARRIER]) begin
        irq_pending <= 1'b1;
      end else if (|(interrupt_status & ~prev_status & interrupt_mask & 8'h7d)) begin
        irq_pending <= 1'b1;
      end else if (status_read) begin
        irq_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b1;
    end else begin
      irq <= irq_pending ~^ link_control[BIT_IRQPOL];
    end
  end

  // pin two drives only when both enable and function agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      general_pin_two_out <= 1'b1;
      general_pin_two_oe <= 1'b0;
    end else begin
      general_pin_two_oe <= modem_feature_control[BIT_CPIN]
                            && (func_sync1 == CPIN_FUNC_CARRIER);
      general_pin_two_out <= ~carrier_now;
    end
  end

  // edge memory sits behind the second stage so the first stays private
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tone_prev <= 1'b0;
      wait_prev <= 1'b0;
    end else begin
      tone_prev <= tone_sync[1];
      wait_prev <= wait_sync[1];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start_dial <= 1'b0;
    end else begin
      start_dial <= (modem_mode_select[BIT_BLIND] && tone_prev && !tone_sync[1])
                    || (modem_feature_control[BIT_TBLIND] && wait_prev
                        && !wait_sync[1]);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_rate <= MMIR_RATE_1200;
      rx_rate <= MMIR_RATE_1200;
    end else begin
      unique case ({modem_mode_select[BIT_V23_RECEIVE_SIDE], modem_mode_select[BIT_V23_TRANSMIT_SIDE]})
        2'b10: begin
          tx_rate <= MMIR_RATE_75;
          rx_rate <= modem_mode_select[BIT_BAUD] ? MMIR_RATE_1200 : MMIR_RATE_600;
        end
        2'b01: begin
          tx_rate <= modem_mode_select[BIT_BAUD] ? MMIR_RATE_1200 : MMIR_RATE_600;
          rx_rate <= MMIR_RATE_75;
        end
        2'b00: begin
          tx_rate <= modem_mode_select[BIT_BAUD] ? MMIR_RATE_2400 : MMIR_RATE_1200;
          rx_rate <= modem_mode_select[BIT_BAUD] ? MMIR_RATE_2400 : MMIR_RATE_1200;
        end
        2'b11: begin
          tx_rate <= modem_mode_select[BIT_BAUD] ? MMIR_RATE_1200 : MMIR_RATE_600;
          rx_rate <= modem_mode_select[BIT_BAUD] ? MMIR_RATE_1200 : MMIR_RATE_600;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ccitt_mode <= 1'b0;
      fsk_300 <= 1'b0;
      caller_monitor_sel <= MMIR_CMON_OFF;
      caller_need_seizure <= 1'b0;
      extra_bit_alert <= 1'b0;
      extra_bit_frame_end <= 1'b0;
      band_swap_loopback <= 1'b0;
    end else begin
      ccitt_mode <= modem_mode_select[BIT_CCITT];
      fsk_300 <= modem_mode_select[BIT_FSK];
      // reserved monitor code is treated as disabled
      caller_monitor_sel <= (modem_feature_control[BIT_CMON +: 2] == MMIR_CMON_RSVD)
                            ? MMIR_CMON_OFF
                            : mmir_cmon_t'(modem_feature_control[BIT_CMON +: 2]);
      caller_need_seizure <= modem_feature_control[BIT_CMON +: 2] == MMIR_CMON_SEIZE;
      extra_bit_alert <= link_control[BIT_ESC] && !modem_feature_control[BIT_XBIT];
      extra_bit_frame_end <= link_control[BIT_ESC] && modem_feature_control[BIT_XBIT];
      band_swap_loopback <= modem_feature_control[BIT_LOOP];
    end
  end

  sequence s_read_status;
    status_read;
  endsequence

  chk_bus_answer: assert property (@(posedge clock) disable iff (!arst_n)
    (bus_state == MMIR_BUS_ANSWER) |=> !waitrequest ##1 waitrequest)
    else $error("answer strobe not one cycle");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!arst_n)
    (interrupt_status[1] == 1'b0) && (modem_mode_select[7] == 1'b0)
    && (modem_feature_control[4] == 1'b0) && (modem_mode_select[3] == 1'b0)
    && (interrupt_mask[1] == 1'b0) && (modem_feature_control[0] == 1'b0))
    else $error("reserved bit set");
  chk_flag_clear: assert property (@(posedge clock) disable iff (!arst_n)
    s_read_status ##0 !event_set[BIT_WAKE] |=> !interrupt_status[BIT_WAKE])
    else $error("wake flag kept after read");
  chk_set_wins: assert property (@(posedge clock) disable iff (!arst_n)
    event_set[BIT_NOLINE] |=> interrupt_status[BIT_NOLINE])
    else $error("no-line event lost");
  chk_ring_onhook: assert property (@(posedge clock) disable iff (!arst_n)
    ring_sync[1] && !onhook_sync[1] && !interrupt_status[BIT_RING] && !status_read
    |=> !interrupt_status[BIT_RING])
    else $error("ring latched off-hook");
  chk_carrier_loss: assert property (@(posedge clock) disable iff (!arst_n)
    interrupt_mask[BIT_CARRIER] && prev_status[BIT_CARRIER] && !interrupt_status[BIT_CARRIER]
    |=> ##1 (irq == link_control[BIT_IRQPOL]))
    else $error("carrier loss gave no interrupt");
  chk_irq_hold: assert property (@(posedge clock) disable iff (!arst_n)
    irq_pending && !status_read |=> irq_pending)
    else $error("interrupt dropped without read");
  chk_v23_rates: assert property (@(posedge clock) disable iff (!arst_n)
    modem_mode_select[BIT_V23_RECEIVE_SIDE] && !modem_mode_select[BIT_V23_TRANSMIT_SIDE] |=> tx_rate == MMIR_RATE_75)
    else $error("v23 receive send rate wrong");
  chk_pin_enable: assert property (@(posedge clock) disable iff (!arst_n)
    !modem_feature_control[BIT_CPIN] |=> !general_pin_two_oe)
    else $error("pin two driven while disabled");
  chk_blind_off: assert property (@(posedge clock) disable iff (!arst_n)
    !modem_mode_select[BIT_BLIND] && !modem_feature_control[BIT_TBLIND] |=> !start_dial)
    else $error("dial started with blind dialing off");
  chk_carrier_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    carrier_now |=> interrupt_status[BIT_CARRIER])
    else $error("carrier flag not set");
  chk_cmon_reserved: assert property (@(posedge clock) disable iff (!arst_n)
    modem_feature_control[BIT_CMON +: 2] == 2'h2 |=> caller_monitor_sel == MMIR_CMON_OFF)
    else $error("reserved monitor code not disabled");
  chk_loop_copy: assert property (@(posedge clock) disable iff (!arst_n)
    modem_feature_control[BIT_LOOP] |=> band_swap_loopback)
    else $error("loopback not applied");
  chk_rev_irq: assert property (@(posedge clock) disable iff (!arst_n)
    interrupt_mask[BIT_REV] && interrupt_status[BIT_REV] && !prev_status[BIT_REV]
    |=> irq_pending)
    else $error("reversal gave no interrupt");
endmodule

//--- mmir_host.sv
// host processor model that issues register bus transfers
`timescale 1ns/10ps
module mmir_host (
  input wire logic clock,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  input wire logic [1:0] response,
  output logic [3:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  output logic [1:0] pin_func
);
  logic [1:0] last_resp;
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h1;
    pin_func = 2'h0;
  end
  // the carrier pin needs this field as well as the enable bit
  task automatic set_func(input logic [1:0] f);
    @(posedge clock);
    pin_func <= f;
  endtask
  // held until waitrequest samples low; only the bench watchdog ends a dead wait
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    last_resp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

//--- test_modem_mode_and_interrupt_regs.sv
// self-checking bench for the modem mode and interrupt register bank
`timescale 1ns/10ps
module test_modem_mode_and_interrupt_regs;
  import mmir_pkg::*;
  logic clock, arst_n, read, write, waitrequest, carrier_pin_n, irq, pin_out, pin_oe;
  logic start_dial, ccitt_mode, fsk_300, seize, xb_alert, xb_end, loopb;
  logic [3:0] address, byteenable, ra;
  logic [31:0] writedata, readdata, q;
  logic [1:0] response, pfunc;
  logic [9:0] ev;
  logic [7:0] rv, mk;
  mmir_rate_t tx_rate, rx_rate;
  mmir_cmon_t cmon;
  int n_fail = 0, checked = 0, seed = 32'h153e, dials = 0, st = 0, pend = 0, pol = 0;
  int m[5] = '{MODE_RESET, MASK_RESET, 0, FEATURE_RESET, CONTROL_RESET};
  int wm[5] = '{MODE_WMASK, MASK_WMASK, 0, FEATURE_WMASK, CONTROL_WMASK};
  int src_ev[6] = '{0, 1, 3, 4, 6, 7};
  int src_bit[6] = '{6, 5, 4, 3, 2, 0};
  mmir_regs dut (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .carrier_pin_n(carrier_pin_n),
    .wake_event(ev[0]), .extension_event(ev[1]), .off_hook_event(ev[2]),
    .line_absent_event(ev[3]), .ring_event(ev[4]), .on_hook(ev[5]),
    .caller_preamble(ev[6]), .reversal_event(ev[7]), .tone_dial_cmd(ev[8]),
    .dial_wait_expired(ev[9]), .general_pin_two_func(pfunc), .irq(irq),
    .general_pin_two_out(pin_out), .general_pin_two_oe(pin_oe), .start_dial(start_dial),
    .tx_rate(tx_rate), .rx_rate(rx_rate), .ccitt_mode(ccitt_mode), .fsk_300(fsk_300),
    .caller_monitor_sel(cmon), .caller_need_seizure(seize), .extra_bit_alert(xb_alert),
    .extra_bit_frame_end(xb_end), .band_swap_loopback(loopb));
  mmir_host u_host (.clock(clock), .waitrequest(waitrequest), .readdata(readdata),
    .response(response), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .pin_func(pfunc));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    if (start_dial === 1'b1)
      dials++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("%s finished, %0d mismatches so far", s, n_fail);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
    check(u_host.last_resp, (a > 4) ? 2'h2 : 2'h0);
    if (a < 5 && a != 2)
      m[a] = d & wm[a];
    if (a == ADDR_CONTROL)
      pol = d[0];
  endtask
  task automatic rd(input logic [3:0] a);
    u_host.xfer(1'b0, a, 8'h00, q);
    check(u_host.last_resp, (a > 4) ? 2'h2 : 2'h0);
    check(q, (a > 4) ? 0 : (a == 2) ? st : m[a]);
    if (a == 2) begin
      st = 0;
      pend = 0;
    end
  endtask
  // inactive level is the inverse of the programmed polarity
  task automatic irq_chk();
    check(irq, pend ? pol : !pol);
  endtask
  task automatic fire(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    repeat (3) @(posedge clock);
    ev[i] <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  function automatic logic [7:0] rates(input logic [7:0] md);
    logic [3:0] b;
    logic [3:0] v;
    b = md[BIT_BAUD] ? MMIR_RATE_2400 : MMIR_RATE_1200;
    v = md[BIT_BAUD] ? MMIR_RATE_1200 : MMIR_RATE_600;
    case ({md[BIT_V23_RECEIVE_SIDE], md[BIT_V23_TRANSMIT_SIDE]})
      2'b00: return {b, b};
      2'b10: return {MMIR_RATE_75, v};
      2'b01: return {v, MMIR_RATE_75};
      default: return {v, v};
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_of_test();
  end
  initial begin
    arst_n = 1'b0;
    carrier_pin_n = 1'b1;
    ev = 10'h0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 6; a++)
      rd(a == 5 ? 4'h9 : a[3:0]);
    irq_chk();
    wr(4'hc, 8'hff);
    rd(4'hc);
    done("reset values");
    // random values also sweep the interrupt polarity
    for (int k = 0; k < 24; k++) begin
      ra = (k % 4 == 2) ? ADDR_CONTROL : 4'(k % 4);
      rv = 8'($random(seed));
      wr(ra, rv);
      rd(ra);
      irq_chk();
    end
    done("readback");
    for (int k = 0; k < 8; k++) begin
      rv = (8'($random(seed)) & 8'h43) | {2'h0, k[1:0], 1'b0, k[2], 2'h0};
      wr(ADDR_MODE, rv);
      repeat (3) @(posedge clock);
      check({tx_rate, rx_rate}, rates(rv));
      check({ccitt_mode, fsk_300}, rv[1:0]);
    end
    done("mode decode");
    for (int k = 0; k < 16; k++) begin
      rv = {k[0], k[2:1], 1'b0, k[3], 1'b0, k[0], 1'b0};
      u_host.set_func(k < 12 ? CPIN_FUNC_CARRIER : 2'h2);
      wr(ADDR_FEATURE, rv);
      wr(ADDR_CONTROL, {6'h0, k[2], 1'b0});
      repeat (3) @(posedge clock);
      check(cmon, (rv[6:5] == 2'h2) ? 2'h0 : rv[6:5]);
      check(seize, rv[6:5] == 2'h1);
      check({xb_alert, xb_end}, {k[2] & !k[3], k[2] & k[3]});
      check(loopb, rv[1]);
      check({pin_oe, pin_out}, {rv[7] & (k < 12), carrier_pin_n});
    end
    done("feature decode");
    fire(4);
    fire(1);
    rd(ADDR_STATUS);
    fire(2);
    ev[5] <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CONTROL, 8'(p >> 1));
      for (int s = 0; s < 6; s++) begin
        mk = p[0] ? ~(8'h1 << src_bit[s]) : (8'h1 << src_bit[s]);
        wr(ADDR_MASK, mk);
        fire(src_ev[s]);
        st = st | (1 << src_bit[s]);
        pend = mk[src_bit[s]];
        repeat (10) @(posedge clock);
        irq_chk();
        rd(ADDR_STATUS);
        repeat (4) @(posedge clock);
        irq_chk();
      end
    end
    done("event flags");
    // carrier loss shows only once the read drops the sticky flag
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_MASK, p ? 8'h80 : 8'h00);
      @(posedge clock);
      carrier_pin_n <= 1'b0;
      repeat (6) @(posedge clock);
      check(pin_out, 1'b0);
      carrier_pin_n <= 1'b1;
      repeat (6) @(posedge clock);
      irq_chk();
      st = 8'h80;
      rd(ADDR_STATUS);
      pend = p;
      repeat (6) @(posedge clock);
      irq_chk();
      rd(ADDR_STATUS);
      repeat (4) @(posedge clock);
      irq_chk();
    end
    done("carrier");
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_MODE, {1'b0, p[0], 6'h06});
      wr(ADDR_FEATURE, {5'h0, p[1], 2'h0});
      dials = 0;
      fire(8);
      check(dials, p[0]);
      dials = 0;
      fire(9);
      check(dials, p[1]);
    end
    done("dialing");
    end_of_test();
  end
endmodule
